//--- xfer_exchange_regs.vh
// Constants of the register transfer and exchange group
// Assumes opcodes arrive as full 16-bit words, page byte first
// Overview of operation
// - Opcode 276c, two cycles: copy X pair into Z pair, X untouched.
// - Opcode 274d, two cycles: copy Y pair into X pair.
// - Opcode 276d, two cycles: copy Y pair into Z pair.
// - Opcode 274e, two cycles: copy Z pair into X pair.
// - Opcode 275e, two cycles: copy Z pair into Y pair.
// - Opcode 37ad, two cycles: Y bank into B low nibble, B high nibble zero.
// - Opcode 37ae, two cycles: Z bank into B low nibble, B high nibble zero.
// - Opcode 375e, two cycles: stack pair gets Y pair minus two.
// - Opcode 376e, two cycles: stack pair gets Z pair minus two.
// - Opcode 27f3 takes eight cycles, then halts until interrupt; flags untouched.
// - Opcode 37dc, two cycles: swap accumulator D with index Y.
// - Opcode 37ec, two cycles: swap accumulator D with index Z.
// - Opcode 374c, two cycles: swap accumulator E with index X.
// - Opcode 375c, two cycles: swap accumulator E with index Y.
// - Opcode 376c, two cycles: swap accumulator E with index Z.
// - Result update writes condition bits 15 to 4, program bank kept.
// - Stack restore replaces all sixteen condition code bits.
// - Bank restore replaces only the program bank field.
// - Each index and stack word pairs with a 4-bit bank as 20 bits.
`ifndef XFER_EXCHANGE_REGS_VH
`define XFER_EXCHANGE_REGS_VH
`define COPY_XPAIR_TO_ZPAIR   16'h276c
`define COPY_YPAIR_TO_XPAIR   16'h274d
`define COPY_YPAIR_TO_ZPAIR   16'h276d
`define COPY_ZPAIR_TO_XPAIR   16'h274e
`define COPY_ZPAIR_TO_YPAIR   16'h275e
`define COPY_YBANK_TO_ACCB    16'h37ad
`define COPY_ZBANK_TO_ACCB    16'h37ae
`define LOAD_STACK_FROM_YPAIR 16'h375e
`define LOAD_STACK_FROM_ZPAIR 16'h376e
`define WAIT_FOR_IRQ_OP       16'h27f3
`define SWAP_ACCD_YINDEX      16'h37dc
`define SWAP_ACCD_ZINDEX      16'h37ec
`define SWAP_ACCE_XINDEX      16'h374c
`define SWAP_ACCE_YINDEX      16'h375c
`define SWAP_ACCE_ZINDEX      16'h376c
`define CYC_XFER              4'h2
`define CYC_WAIT              4'h8
`define STACK_ADJ             20'h00002
`define BANK_MSB              3
`define COND_MSB              15
`define CONDM_NONE            2'h0
`define CONDM_RESULT          2'h1
`define CONDM_FULL            2'h2
`define CONDM_BANK            2'h3
`define LOAD_ACCD             4'h0
`define LOAD_ACCE             4'h1
`define LOAD_XPAIR            4'h2
`define LOAD_YPAIR            4'h3
`define LOAD_ZPAIR            4'h4
`define LOAD_STACK            4'h5
`define RESET_WORD            16'h0000
`define RESET_BANK            4'h0
`endif

//--- sync_2ff.v
// Two flip-flop synchroniser with asynchronous clear
// Assumes the clear is active low and the input may be asynchronous
`timescale 1ns/100ps
module sync_2ff (
    // Clock and clear
    input  wire clk,
    input  wire clrN,
    // Data
    input  wire d,
    output reg  q
);
    reg meta;

    always @(posedge clk or negedge clrN) begin
        if (!clrN) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync_2ff

//--- addr_pair.v
// One 16-bit address word paired with its 4-bit bank field
// Assumes load strobes come from logic on the same clock
`timescale 1ns/100ps
`include "xfer_exchange_regs.vh"
module addr_pair #(
    parameter WW = 16,
    parameter BW = 4
) (
    // Clock and reset
    input  wire               clk,
    input  wire               rstN,
    // Load controls
    input  wire               ldPair,
    input  wire               ldWord,
    input  wire [WW+BW-1:0]   ldVal,
    // Stored state
    output reg  [BW-1:0]      bank,
    output reg  [WW-1:0]      word
);
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bank <= `RESET_BANK;
            word <= `RESET_WORD;
        end else if (ldPair) begin
            bank <= ldVal[WW+BW-1:WW];
            word <= ldVal[WW-1:0];
        end else if (ldWord) begin
            word <= ldVal[WW-1:0];
        end
    end
endmodule // addr_pair

//--- register_transfer_exchange_ops.v
// Decode and execution of the pair transfer, bank copy, stack load,
// exchange and wait-for-interrupt group, with condition code update.
// Assumes one opcode per issue handshake and a level interrupt request.
`timescale 1ns/100ps
`include "xfer_exchange_regs.vh"
module register_transfer_exchange_ops #(
    parameter CW = 4
) (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Instruction issue
    input  wire        opValid,
    input  wire [15:0] opcode,
    output reg         opReady,
    output reg         opDone,
    output reg         illegalOp,
    // Wait and wake
    input  wire        irqRequest,
    output reg         waiting,
    output reg         woken,
    // Register load from the core
    input  wire        loadEn,
    input  wire [3:0]  loadSel,
    input  wire [19:0] loadData,
    // Condition code update
    input  wire        condWrEn,
    input  wire [1:0]  condMode,
    input  wire [15:0] condData,
    // Accumulators and condition codes
    output reg  [15:0] accD,
    output reg  [15:0] accE,
    output reg  [15:0] condCode,
    // Index and stack pairs
    output wire [3:0]  xBank,
    output wire [15:0] indexX,
    output wire [3:0]  yBank,
    output wire [15:0] indexY,
    output wire [3:0]  zBank,
    output wire [15:0] indexZ,
    output wire [3:0]  stackBank,
    output wire [15:0] stackPointer
);
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_WAIT = 2'h2;
    wire          rstN;
    wire          irqSync;
    reg  [1:0]    state;
    reg  [15:0]   cmd;
    reg           cmdKnown;
    reg  [CW-1:0] count;
    reg           decKnown;
    reg  [CW-1:0] decCycles;
    wire          accept;
    wire          commit;
    reg  [15:0]   next_accD;
    reg  [15:0]   next_accE;
    reg           xLdPair;
    reg           xLdWord;
    reg  [19:0]   xVal;
    reg           yLdPair;
    reg           yLdWord;
    reg  [19:0]   yVal;
    reg           zLdPair;
    reg           zLdWord;
    reg  [19:0]   zVal;
    reg           sLdPair;
    reg  [19:0]   sVal;
    wire [19:0]   xPair;
    wire [19:0]   yPair;
    wire [19:0]   zPair;
    wire [19:0]   yLess;
    wire [19:0]   zLess;
    reg  [15:0]   next_condCode;

    // Reset release
    sync_2ff rstSync (
        .clk  (clk),
        .clrN (nrst),
        .d    (1'b1),
        .q    (rstN)
    );

    // Interrupt request
    sync_2ff irqSyncer (
        .clk  (clk),
        .clrN (rstN),
        .d    (irqRequest),
        .q    (irqSync)
    );

    assign xPair  = {xBank, indexX};
    assign yPair  = {yBank, indexY};
    assign zPair  = {zBank, indexZ};
    assign yLess  = yPair - `STACK_ADJ;
    assign zLess  = zPair - `STACK_ADJ;
    assign accept = opValid && opReady;
    assign commit = (state == ST_EXEC) && (count == {{(CW-1){1'b0}}, 1'b1});

    // Opcode decode
    always @* begin
        decKnown  = 1'b1;
        decCycles = `CYC_XFER;
        case (opcode)
            `COPY_XPAIR_TO_ZPAIR,
            `COPY_YPAIR_TO_XPAIR,
            `COPY_YPAIR_TO_ZPAIR,
            `COPY_ZPAIR_TO_XPAIR,
            `COPY_ZPAIR_TO_YPAIR,
            `COPY_YBANK_TO_ACCB,
            `COPY_ZBANK_TO_ACCB,
            `LOAD_STACK_FROM_YPAIR,
            `LOAD_STACK_FROM_ZPAIR,
            `SWAP_ACCD_YINDEX,
            `SWAP_ACCD_ZINDEX,
            `SWAP_ACCE_XINDEX,
            `SWAP_ACCE_YINDEX,
            `SWAP_ACCE_ZINDEX: decCycles = `CYC_XFER;
            `WAIT_FOR_IRQ_OP: decCycles = `CYC_WAIT;
            default: decKnown = 1'b0;
        endcase
    end

    // Sequencer
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state     <= ST_IDLE;
            cmd       <= 16'h0000;
            cmdKnown  <= 1'b0;
            count     <= {CW{1'b0}};
            opReady   <= 1'b0;
            opDone    <= 1'b0;
            illegalOp <= 1'b0;
            waiting   <= 1'b0;
            woken     <= 1'b0;
        end else begin
            opDone    <= 1'b0;
            illegalOp <= 1'b0;
            woken     <= 1'b0;
            case (state)
                ST_IDLE: begin
                    opReady <= 1'b1;
                    if (accept) begin
                        cmd      <= opcode;
                        cmdKnown <= decKnown;
                        count    <= decCycles - {{(CW-1){1'b0}}, 1'b1};
                        opReady  <= 1'b0;
                        state    <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    count <= count - {{(CW-1){1'b0}}, 1'b1};
                    if (commit) begin
                        if (cmd == `WAIT_FOR_IRQ_OP) begin
                            waiting <= 1'b1;
                            state   <= ST_WAIT;
                        end else begin
                            opDone    <= 1'b1;
                            illegalOp <= !cmdKnown;
                            opReady   <= 1'b1;
                            state     <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (irqSync) begin
                        waiting <= 1'b0;
                        woken   <= 1'b1;
                        opDone  <= 1'b1;
                        opReady <= 1'b1;
                        state   <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Execution datapath
    always @* begin
        next_accD = accD;
        next_accE = accE;
        xLdPair   = 1'b0;
        xLdWord   = 1'b0;
        xVal      = xPair;
        yLdPair   = 1'b0;
        yLdWord   = 1'b0;
        yVal      = yPair;
        zLdPair   = 1'b0;
        zLdWord   = 1'b0;
        zVal      = zPair;
        sLdPair   = 1'b0;
        sVal      = {stackBank, stackPointer};
        if (commit) begin
            case (cmd)
                `COPY_XPAIR_TO_ZPAIR: begin
                    zLdPair = 1'b1;
                    zVal    = xPair;
                end
                `COPY_YPAIR_TO_XPAIR: begin
                    xLdPair = 1'b1;
                    xVal    = yPair;
                end
                `COPY_YPAIR_TO_ZPAIR: begin
                    zLdPair = 1'b1;
                    zVal    = yPair;
                end
                `COPY_ZPAIR_TO_XPAIR: begin
                    xLdPair = 1'b1;
                    xVal    = zPair;
                end
                `COPY_ZPAIR_TO_YPAIR: begin
                    yLdPair = 1'b1;
                    yVal    = zPair;
                end
                `COPY_YBANK_TO_ACCB: next_accD = {accD[15:8], 4'h0, yBank};
                `COPY_ZBANK_TO_ACCB: next_accD = {accD[15:8], 4'h0, zBank};
                `LOAD_STACK_FROM_YPAIR: begin
                    sLdPair = 1'b1;
                    sVal    = yLess;
                end
                `LOAD_STACK_FROM_ZPAIR: begin
                    sLdPair = 1'b1;
                    sVal    = zLess;
                end
                `SWAP_ACCD_YINDEX: begin
                    next_accD = indexY;
                    yLdWord   = 1'b1;
                    yVal      = {yBank, accD};
                end
                `SWAP_ACCD_ZINDEX: begin
                    next_accD = indexZ;
                    zLdWord   = 1'b1;
                    zVal      = {zBank, accD};
                end
                `SWAP_ACCE_XINDEX: begin
                    next_accE = indexX;
                    xLdWord   = 1'b1;
                    xVal      = {xBank, accE};
                end
                `SWAP_ACCE_YINDEX: begin
                    next_accE = indexY;
                    yLdWord   = 1'b1;
                    yVal      = {yBank, accE};
                end
                `SWAP_ACCE_ZINDEX: begin
                    next_accE = indexZ;
                    zLdWord   = 1'b1;
                    zVal      = {zBank, accE};
                end
                default: next_accD = accD;
            endcase
        end else if (loadEn && opReady) begin
            case (loadSel)
                `LOAD_ACCD: next_accD = loadData[15:0];
                `LOAD_ACCE: next_accE = loadData[15:0];
                `LOAD_XPAIR: begin
                    xLdPair = 1'b1;
                    xVal    = loadData;
                end
                `LOAD_YPAIR: begin
                    yLdPair = 1'b1;
                    yVal    = loadData;
                end
                `LOAD_ZPAIR: begin
                    zLdPair = 1'b1;
                    zVal    = loadData;
                end
                `LOAD_STACK: begin
                    sLdPair = 1'b1;
                    sVal    = loadData;
                end
                default: next_accD = accD;
            endcase
        end
    end

    // Condition code update
    always @* begin
        next_condCode = condCode;
        if (condWrEn) begin
            case (condMode)
                `CONDM_RESULT: next_condCode = {condData[`COND_MSB:`BANK_MSB+1],
                                                condCode[`BANK_MSB:0]};
                `CONDM_FULL: next_condCode = condData;
                `CONDM_BANK: next_condCode = {condCode[`COND_MSB:`BANK_MSB+1],
                                              condData[`BANK_MSB:0]};
                default: next_condCode = condCode;
            endcase
        end
    end

    // Accumulators and condition codes
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            accD     <= `RESET_WORD;
            accE     <= `RESET_WORD;
            condCode <= `RESET_WORD;
        end else begin
            accD     <= next_accD;
            accE     <= next_accE;
            condCode <= next_condCode;
        end
    end

    // Index X pair
    addr_pair xPairReg (
        .clk    (clk),
        .rstN   (rstN),
        .ldPair (xLdPair),
        .ldWord (xLdWord),
        .ldVal  (xVal),
        .bank   (xBank),
        .word   (indexX)
    );
    // Index Y pair
    addr_pair yPairReg (
        .clk    (clk),
        .rstN   (rstN),
        .ldPair (yLdPair),
        .ldWord (yLdWord),
        .ldVal  (yVal),
        .bank   (yBank),
        .word   (indexY)
    );
    // Index Z pair
    addr_pair zPairReg (
        .clk    (clk),
        .rstN   (rstN),
        .ldPair (zLdPair),
        .ldWord (zLdWord),
        .ldVal  (zVal),
        .bank   (zBank),
        .word   (indexZ)
    );
    // Stack pair
    addr_pair sPairReg (
        .clk    (clk),
        .rstN   (rstN),
        .ldPair (sLdPair),
        .ldWord (1'b0),
        .ldVal  (sVal),
        .bank   (stackBank),
        .word   (stackPointer)
    );
endmodule // register_transfer_exchange_ops

//--- xfer_ops_monitor.sv
// Checker for the transfer and exchange group at the top ports
// Assumes it is bound into register_transfer_exchange_ops
`timescale 1ns/100ps
`include "xfer_exchange_regs.vh"
module xfer_ops_monitor (
    // Clock and reset
    input wire        clk,
    input wire        nrst,
    // Issue and wait
    input wire        opValid,
    input wire [15:0] opcode,
    input wire        opReady,
    input wire        opDone,
    input wire        irqRequest,
    input wire        waiting,
    input wire        woken,
    // Condition codes
    input wire        condWrEn,
    input wire [1:0]  condMode,
    input wire [15:0] condData,
    input wire [15:0] condCode,
    // Registers
    input wire [15:0] accD,
    input wire [3:0]  xBank,
    input wire [15:0] indexX,
    input wire [3:0]  yBank,
    input wire [15:0] indexY,
    input wire [3:0]  zBank,
    input wire [15:0] indexZ,
    input wire [3:0]  stackBank,
    input wire [15:0] stackPointer
);
    wire        take  = opValid && opReady;
    wire [19:0] xPair = {xBank, indexX};
    wire [19:0] zPair = {zBank, indexZ};
    wire [19:0] sPair = {stackBank, stackPointer};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_two_cycle: assert property (take && opcode != `WAIT_FOR_IRQ_OP
        |=> !opReady && !opDone ##1 opDone && opReady) else $error("short op timing wrong");
    chk_x_to_z: assert property (take && opcode == `COPY_XPAIR_TO_ZPAIR
        |=> ##1 zPair == $past(xPair, 2) && xPair == $past(xPair, 2)) else $error("x copy wrong");
    chk_ybank_accb: assert property (take && opcode == `COPY_YBANK_TO_ACCB
        |=> ##1 accD[7:0] == {4'h0, $past(yBank, 2)}) else $error("y bank copy wrong");
    chk_stack_z: assert property (take && opcode == `LOAD_STACK_FROM_ZPAIR
        |=> ##1 sPair == $past(zPair, 2) - `STACK_ADJ) else $error("stack load wrong");
    chk_swap_dy: assert property (take && opcode == `SWAP_ACCD_YINDEX
        |=> ##1 accD == $past(indexY, 2) && indexY == $past(accD, 2)) else $error("swap wrong");
    chk_wait_eight: assert property (take && opcode == `WAIT_FOR_IRQ_OP && !irqRequest
        |=> (!waiting && !opReady) [*7] ##1 waiting) else $error("wait entry wrong");
    chk_wake_bound: assert property (waiting && irqRequest
        |-> ##[1:4] (woken && opDone)) else $error("wake late");
    chk_flags_kept: assert property (!condWrEn |=> $stable(condCode))
        else $error("flags changed");
    chk_cond_result: assert property (condWrEn && condMode == `CONDM_RESULT
        |=> (condCode & 16'hfff0) == ($past(condData) & 16'hfff0)
        && (condCode & 16'h000f) == ($past(condCode) & 16'h000f)) else $error("result update wrong");
    chk_cond_full: assert property (condWrEn && condMode == `CONDM_FULL
        |=> condCode == $past(condData)) else $error("full restore wrong");
    chk_cond_bank: assert property (condWrEn && condMode == `CONDM_BANK
        |=> (condCode & 16'h000f) == ($past(condData) & 16'h000f)
        && (condCode & 16'hfff0) == ($past(condCode) & 16'hfff0)) else $error("bank restore wrong");
    cover property (take && opcode == `WAIT_FOR_IRQ_OP);
    cover property (woken);
    cover property (condWrEn && condMode == `CONDM_BANK);
endmodule // xfer_ops_monitor

bind register_transfer_exchange_ops xfer_ops_monitor u_xfer_ops_monitor (
    .clk, .nrst, .opValid, .opcode, .opReady, .opDone, .irqRequest, .waiting, .woken,
    .condWrEn, .condMode, .condData, .condCode, .accD, .xBank, .indexX, .yBank, .indexY,
    .zBank, .indexZ, .stackBank, .stackPointer
);

//--- test_register_transfer_exchange_ops.sv
// Self-checking bench for the transfer and exchange group
// Assumes the checker file binds itself into the design
`timescale 1ns/100ps
`include "xfer_exchange_regs.vh"
module test_register_transfer_exchange_ops;
    localparam [255:0] OPS = {16'h371a, `WAIT_FOR_IRQ_OP, `COPY_ZPAIR_TO_YPAIR, `COPY_ZPAIR_TO_XPAIR,
        `COPY_YPAIR_TO_ZPAIR, `COPY_YPAIR_TO_XPAIR, `COPY_XPAIR_TO_ZPAIR, `COPY_ZBANK_TO_ACCB,
        `COPY_YBANK_TO_ACCB, `SWAP_ACCE_ZINDEX, `SWAP_ACCE_YINDEX, `SWAP_ACCE_XINDEX,
        `SWAP_ACCD_ZINDEX, `SWAP_ACCD_YINDEX, `LOAD_STACK_FROM_ZPAIR, `LOAD_STACK_FROM_YPAIR};
    reg         clk, nrst, opValid, irqRequest, loadEn, condWrEn;
    reg  [15:0] opcode, condData;
    reg  [3:0]  loadSel;
    reg  [19:0] loadData;
    reg  [1:0]  condMode;
    wire        opReady, opDone, illegalOp, waiting, woken;
    wire [15:0] accD, accE, condCode, indexX, indexY, indexZ, stackPointer;
    wire [3:0]  xBank, yBank, zBank, stackBank;
    reg  [19:0] ex, ey, ez, es;
    reg  [15:0] ed, ee, ec;
    integer     n_fail, n_checks, i;

    register_transfer_exchange_ops u_register_transfer_exchange_ops (
        .clk, .nrst, .opValid, .opcode, .opReady, .opDone, .illegalOp, .irqRequest, .waiting,
        .woken, .loadEn, .loadSel, .loadData, .condWrEn, .condMode, .condData, .accD, .accE,
        .condCode, .xBank, .indexX, .yBank, .indexY, .zBank, .indexZ, .stackBank, .stackPointer
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task check(input string name, input [95:0] seen, input [95:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task bound(input integer k, input integer lim);
        begin
            if (k >= lim) begin
                n_fail = n_fail + 1;
                summarize;
            end
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    task resetDut;
        integer k;
        begin
            @(posedge clk);
            nrst <= 1'b0;
            repeat (16) @(posedge clk);
            nrst <= 1'b1;
            k = 0;
            @(negedge clk);
            while (opReady !== 1'b1 && k < 50) begin
                k = k + 1;
                @(negedge clk);
            end
            bound(k, 50);
            check("resetState", {accD, condCode, xBank, indexX, stackPointer}, 0);
        end
    endtask

    task load(input [3:0] sel, input [19:0] data);
        begin
            @(posedge clk);
            loadEn   <= 1'b1;
            loadSel  <= sel;
            loadData <= data;
            @(posedge clk);
            loadEn   <= 1'b0;
        end
    endtask

    task setCond(input [1:0] mode, input [15:0] data, input [15:0] exp);
        begin
            @(posedge clk);
            condWrEn <= 1'b1;
            condMode <= mode;
            condData <= data;
            @(posedge clk);
            condWrEn <= 1'b0;
            @(negedge clk);
            check("condCode", condCode, exp);
        end
    endtask

    task runOp(input [15:0] op);
        integer k;
        reg     bad;
        begin
            bad = 1'b0;
            case (op)
                `COPY_XPAIR_TO_ZPAIR: ez = ex;
                `COPY_YPAIR_TO_XPAIR: ex = ey;
                `COPY_YPAIR_TO_ZPAIR: ez = ey;
                `COPY_ZPAIR_TO_XPAIR: ex = ez;
                `COPY_ZPAIR_TO_YPAIR: ey = ez;
                `COPY_YBANK_TO_ACCB: ed = {ed[15:8], 4'h0, ey[19:16]};
                `COPY_ZBANK_TO_ACCB: ed = {ed[15:8], 4'h0, ez[19:16]};
                `LOAD_STACK_FROM_YPAIR: es = ey - `STACK_ADJ;
                `LOAD_STACK_FROM_ZPAIR: es = ez - `STACK_ADJ;
                `SWAP_ACCD_YINDEX: {ed, ey[15:0]} = {ey[15:0], ed};
                `SWAP_ACCD_ZINDEX: {ed, ez[15:0]} = {ez[15:0], ed};
                `SWAP_ACCE_XINDEX: {ee, ex[15:0]} = {ex[15:0], ee};
                `SWAP_ACCE_YINDEX: {ee, ey[15:0]} = {ey[15:0], ee};
                `SWAP_ACCE_ZINDEX: {ee, ez[15:0]} = {ez[15:0], ee};
                `WAIT_FOR_IRQ_OP: bad = 1'b0;
                default: bad = 1'b1;
            endcase
            @(posedge clk);
            opValid <= 1'b1;
            opcode  <= op;
            @(posedge clk);
            opValid <= 1'b0;
            k = 1;
            @(negedge clk);
            while (opDone !== 1'b1 && waiting !== 1'b1 && k < 20) begin
                k = k + 1;
                @(negedge clk);
            end
            bound(k, 20);
            check("cycles", k, (op == `WAIT_FOR_IRQ_OP) ? `CYC_WAIT : `CYC_XFER);
            if (op == `WAIT_FOR_IRQ_OP) begin
                check("waiting", waiting, 1);
                @(posedge clk);
                irqRequest <= 1'b1;
                k = 0;
                @(negedge clk);
                while (woken !== 1'b1 && k < 10) begin
                    k = k + 1;
                    @(negedge clk);
                end
                bound(k, 10);
                check("wakeDone", {opDone, waiting}, 2'b10);
                @(posedge clk);
                irqRequest <= 1'b0;
            end else begin
                check("illegal", illegalOp, bad);
            end
            check("xyPairs", {xBank, indexX, yBank, indexY}, {ex, ey});
            check("zsPairs", {zBank, indexZ, stackBank, stackPointer}, {ez, es});
            check("accFlags", {accD, accE, condCode}, {ed, ee, ec});
        end
    endtask

    task backToBack;
        begin
            ex = 20'h11111;
            ey = 20'h2c2c2;
            load(`LOAD_XPAIR, ex);
            load(`LOAD_YPAIR, ey);
            @(posedge clk);
            opValid <= 1'b1;
            opcode  <= `COPY_YPAIR_TO_XPAIR;
            @(posedge clk);
            opcode  <= `COPY_XPAIR_TO_ZPAIR;
            repeat (2) @(posedge clk);
            opValid <= 1'b0;
            @(negedge clk);
            check("b2bFirst", {opReady, xBank, indexX}, {1'b0, ey});
            @(negedge clk);
            check("b2bSecond", {opDone, zBank, indexZ}, {1'b1, ey});
        end
    endtask

    initial begin
        nrst       = 1'b0;
        opValid    = 1'b0;
        opcode     = 16'h0000;
        irqRequest = 1'b0;
        loadEn     = 1'b0;
        loadSel    = 4'h0;
        loadData   = 20'h00000;
        condWrEn   = 1'b0;
        condMode   = 2'h0;
        condData   = 16'h0000;
        n_fail     = 0;
        n_checks   = 0;
        resetDut;
        setCond(`CONDM_FULL, 16'h1234, 16'h1234);
        setCond(`CONDM_RESULT, 16'hffff, 16'hfff4);
        setCond(`CONDM_BANK, 16'h000a, 16'hfffa);
        setCond(`CONDM_NONE, 16'h0000, 16'hfffa);
        setCond(`CONDM_FULL, 16'ha5c3, 16'ha5c3);
        ec = 16'ha5c3;
        ed = 16'h1357;
        ee = 16'h2468;
        es = 20'h1f00e;
        load(`LOAD_ACCD, {4'h0, ed});
        load(`LOAD_ACCE, {4'h0, ee});
        load(`LOAD_STACK, es);
        for (i = 0; i < 16; i = i + 1) begin
            ex = 20'h5abcd + i[19:0];
            ey = 20'h30001 + {i[11:0], 8'h00};
            ez = 20'h90000 + i[19:0];
            load(`LOAD_XPAIR, ex);
            load(`LOAD_YPAIR, ey);
            load(`LOAD_ZPAIR, ez);
            runOp(OPS[i*16 +: 16]);
        end
        backToBack;
        resetDut;
        summarize;
    end
endmodule // test_register_transfer_exchange_ops
